/* rtl/cfg_loader_map.vh */
// Register map, field positions, stream format and timing counts of the configuration loader.
// Assumes byte addresses on a 32-bit Avalon-MM slave port and a 20 MHz system clock.
`ifndef CFG_LOADER_MAP_VH
`define CFG_LOADER_MAP_VH

// Register byte offsets
`define REG_CTRL 6'h00
`define REG_STATUS 6'h04
`define REG_MASK 6'h08
`define REG_GOLDEN 6'h0C
`define REG_UPDATE 6'h10
`define REG_SLAVE_DATA 6'h14
`define REG_RB_ADDR 6'h18
`define REG_RB_DATA 6'h1C
`define REG_KEY_BASE 6'h20

// Control fields
`define CTRL_START 0
`define CTRL_KEY_SRC 1
`define CTRL_EXT_CLK 2

// Sticky event fields of status and mask
`define EV_DONE 0
`define EV_LOAD_ERR 1
`define EV_AUTH_ERR 2
`define EV_FALLBACK 3
`define EV_W 4

// Image header fields
`define HDR_ENC 31
`define HDR_AUTH 30
`define HDR_PART 29
`define HDR_BASE_LSB 16
`define HDR_COUNT_LSB 0

// Width words at the start of a flash image, and the digest start value
`define SYNC_X1 32'hA5A5_0001
`define SYNC_X2 32'hA5A5_0002
`define SYNC_X4 32'hA5A5_0004
`define MAC_INIT 32'h5A5A_C3C3

// Flash read commands and dummy clocks of wide reads
`define CMD_READ_X1 8'h03
`define CMD_READ_X2 8'h3B
`define CMD_READ_X4 8'h6B
`define DUMMY_CLKS 6'h08

// Mode pin codes
`define MODE_MASTER 3'h1
`define MODE_SLAVE 3'h6

// Configuration store size
`define CFG_WORDS 8'h40

// Timing: internal flash clock half period
`define CLK_PERIOD_NS 50
`define SCK_HALF_NS 200
`define SCK_HALF_CYC (`SCK_HALF_NS / `CLK_PERIOD_NS)

`endif

/* rtl/config_bitstream_loader.v */
// Configuration loader: flash master with width detection, slave word port, multiboot, decrypt, readback.
// Assumes flash pins and mode, restart and external clock pins are asynchronous to clock_i.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "cfg_loader_map.vh"

// What this block does
// - Master mode reads image from attached flash
// - Detects one, two or four line width
// - Flash clock from internal divider or external
// - Slave mode takes 32-bit words from host
// - Loads alternate image from flash by itself
// - Error in new image reloads original image
// - Decrypts words on the fly with key
// - Keyed digest rejects altered images
// - Key from key RAM or fuse bits
// - Loaded content readable while running
// - Partial load rewrites only chosen region
// - Restart pin low discards and reloads
module config_bitstream_loader (
	input wire clock_i,
	input wire rst_b_i,
	input wire [5:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	output reg [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	input wire program_b_i,
	input wire [2:0] mode_i,
	input wire ext_cfg_clk_i,
	input wire [255:0] otp_key_fuses_i,
	output reg flash_cs_b_o,
	output reg flash_sck_o,
	input wire [3:0] flash_dq_i,
	output wire [3:0] flash_dq_o,
	output wire [3:0] flash_dq_oe_o,
	output wire done_o,
	output wire irq_o
);
	localparam L_IDLE = 3'h0;
	localparam L_CMD = 3'h1;
	localparam L_DUMMY = 3'h2;
	localparam L_DATA = 3'h3;
	localparam L_GAP = 3'h4;
	localparam L_SLAVE = 3'h5;
	localparam P_WIDTH = 2'h0;
	localparam P_HDR = 2'h1;
	localparam P_BODY = 2'h2;
	localparam P_TAG = 2'h3;

	reg [1:0] prog_s;
	reg [1:0] ext_s;
	reg ext_d;
	reg [3:0] dq_m;
	reg [3:0] dq_s;
	reg [2:0] mode_m;
	reg [2:0] mode_s;
	reg [255:0] fuse_m;
	reg [255:0] fuse_s;
	reg [1:0] div_cnt;
	reg key_src;
	reg ext_sel;
	reg start_pulse;
	reg [`EV_W-1:0] status;
	reg [`EV_W-1:0] mask;
	reg [23:0] golden_addr;
	reg [23:0] update_addr;
	reg [5:0] rb_addr;
	reg [31:0] key_ram [0:7];
	reg [31:0] cfg_mem [0:63];
	reg rd_ack;
	reg [2:0] lstate;
	reg [1:0] pstate;
	reg [2:0] width;
	reg [5:0] cnt;
	reg [31:0] rx;
	reg [31:0] cmd_sr;
	reg [23:0] flash_addr;
	reg using_update;
	reg is_master;
	reg boot_pend;
	reg cfg_valid;
	reg hdr_enc;
	reg hdr_auth;
	reg [5:0] base;
	reg [6:0] count;
	reg [6:0] idx;
	reg [31:0] mac;
	reg word_valid;
	reg [31:0] word_data;
	reg [`EV_W-1:0] events;
	reg bad;
	reg auth_bad;
	reg [255:0] key;
	reg [31:0] next_rx;
	integer i;
	integer j;
	wire tick;
	wire sck_fall;
	wire wr_slave;
	wire [31:0] stream;
	wire [31:0] next_mac;
	wire [31:0] plain;
	wire [5:0] mem_addr;
	wire mem_we;
	wire [7:0] hdr_end;

	// Pin synchronisers; first stages feed only second stages
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prog_s <= 2'h0;
			ext_s <= 2'h0;
			ext_d <= 1'b0;
			dq_m <= 4'h0;
			dq_s <= 4'h0;
			mode_m <= 3'h0;
			mode_s <= 3'h0;
			fuse_m <= 256'h0;
			fuse_s <= 256'h0;
		end else begin
			prog_s <= {prog_s[0], program_b_i};
			ext_s <= {ext_s[0], ext_cfg_clk_i};
			ext_d <= ext_s[1];
			dq_m <= flash_dq_i;
			dq_s <= dq_m;
			mode_m <= mode_i;
			mode_s <= mode_m;
			fuse_m <= otp_key_fuses_i;
			fuse_s <= fuse_m;
		end
	end

	// Half-period tick of the flash clock
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_cnt <= 2'h0;
		end else if (div_cnt == (`SCK_HALF_CYC - 1)) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end
	assign tick = ext_sel ? (ext_s[1] ^ ext_d) : (div_cnt == (`SCK_HALF_CYC - 1));
	assign sck_fall = tick & flash_sck_o;

	// Key source select
	always @* begin
		for (i = 0; i < 8; i = i + 1) begin
			key[i*32 +: 32] = key_src ? fuse_s[i*32 +: 32] : key_ram[i];
		end
	end

	key_stream_cipher u_cipher (
		.key_i(key),
		.index_i({1'b0, idx}),
		.mac_i(mac),
		.word_i(plain),
		.stream_o(stream),
		.mac_o(next_mac)
	);
	assign plain = hdr_enc ? (word_data ^ stream) : word_data;
	assign mem_addr = base + idx[5:0];
	assign mem_we = word_valid & (pstate == P_BODY);
	assign hdr_end = {2'h0, word_data[`HDR_BASE_LSB +: 6]} + {1'b0, word_data[`HDR_COUNT_LSB +: 7]};

	// Word checks
	always @* begin
		bad = 1'b0;
		auth_bad = 1'b0;
		if (word_valid) begin
			case (pstate)
				P_WIDTH: bad = (word_data != `SYNC_X1) && (word_data != `SYNC_X2) && (word_data != `SYNC_X4);
				P_HDR: bad = (word_data[`HDR_COUNT_LSB +: 7] == 7'h00) || (hdr_end > `CFG_WORDS)
					|| (!word_data[`HDR_PART] && (word_data[`HDR_BASE_LSB +: 6] != 6'h00))
					|| (word_data[`HDR_PART] && !cfg_valid);
				P_TAG: begin
					auth_bad = hdr_auth && (word_data != mac);
					bad = auth_bad;
				end
				default: bad = 1'b0;
			endcase
		end
	end

	// Received word after one more beat of the current width
	always @* begin
		case (width)
			3'h2: next_rx = {rx[29:0], dq_s[1:0]};
			3'h4: next_rx = {rx[27:0], dq_s[3:0]};
			default: next_rx = {rx[30:0], dq_s[1]};
		endcase
	end

	// Configuration store; readback never stalls loading
	always @(posedge clock_i) begin
		if (mem_we) begin
			cfg_mem[mem_addr] <= plain;
		end
	end

	// Link sequencer and image parser
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lstate <= L_IDLE;
			pstate <= P_WIDTH;
			width <= 3'h1;
			cnt <= 6'h00;
			rx <= 32'h0000_0000;
			cmd_sr <= 32'h0000_0000;
			flash_addr <= 24'h00_0000;
			flash_cs_b_o <= 1'b1;
			flash_sck_o <= 1'b0;
			using_update <= 1'b0;
			is_master <= 1'b0;
			boot_pend <= 1'b1;
			cfg_valid <= 1'b0;
			hdr_enc <= 1'b0;
			hdr_auth <= 1'b0;
			base <= 6'h00;
			count <= 7'h00;
			idx <= 7'h00;
			mac <= 32'h0000_0000;
			word_valid <= 1'b0;
			word_data <= 32'h0000_0000;
			events <= 4'h0;
		end else begin
			word_valid <= 1'b0;
			events <= 4'h0;
			if (!prog_s[1]) begin
				lstate <= L_IDLE;
				flash_cs_b_o <= 1'b1;
				flash_sck_o <= 1'b0;
				cfg_valid <= 1'b0;
				boot_pend <= 1'b1;
			end else if ((boot_pend || start_pulse) && (lstate == L_IDLE)) begin
				boot_pend <= 1'b0;
				width <= 3'h1;
				cnt <= 6'h00;
				if (mode_s == `MODE_MASTER) begin
					is_master <= 1'b1;
					pstate <= P_WIDTH;
					using_update <= start_pulse & ~boot_pend;
					flash_addr <= (start_pulse & ~boot_pend) ? update_addr : golden_addr;
					cmd_sr <= {`CMD_READ_X1, ((start_pulse & ~boot_pend) ? update_addr : golden_addr)};
					lstate <= L_GAP;
				end else if (mode_s == `MODE_SLAVE) begin
					is_master <= 1'b0;
					pstate <= P_HDR;
					lstate <= L_SLAVE;
				end
			end else begin
				// Flash clocking, command, dummy and data beats
				case (lstate)
					L_GAP: begin
						flash_cs_b_o <= 1'b1;
						flash_sck_o <= 1'b0;
						if (tick && flash_cs_b_o) begin
							flash_cs_b_o <= 1'b0;
							cnt <= 6'h00;
							lstate <= L_CMD;
						end
					end
					L_CMD, L_DUMMY, L_DATA: begin
						if (tick) begin
							flash_sck_o <= ~flash_sck_o;
						end
						if (sck_fall) begin
							if (lstate == L_CMD) begin
								cmd_sr <= {cmd_sr[30:0], 1'b0};
								cnt <= (cnt == 6'h1F) ? 6'h00 : cnt + 6'h01;
								if (cnt == 6'h1F) begin
									lstate <= (width == 3'h1) ? L_DATA : L_DUMMY;
								end
							end else if (lstate == L_DUMMY) begin
								cnt <= (cnt == `DUMMY_CLKS - 6'h01) ? 6'h00 : cnt + 6'h01;
								if (cnt == `DUMMY_CLKS - 6'h01) begin
									lstate <= L_DATA;
								end
							end else begin
								rx <= next_rx;
								if (cnt + {3'h0, width} == 6'h20) begin
									cnt <= 6'h00;
									word_valid <= 1'b1;
									word_data <= next_rx;
								end else begin
									cnt <= cnt + {3'h0, width};
								end
							end
						end
					end
					L_SLAVE: begin
						if (wr_slave) begin
							word_valid <= 1'b1;
							word_data <= avs_writedata_i;
						end
					end
					default: begin
						flash_cs_b_o <= 1'b1;
						flash_sck_o <= 1'b0;
					end
				endcase
				// Parser acts one cycle after each word
				if (bad) begin
					events[`EV_AUTH_ERR] <= auth_bad;
					pstate <= P_WIDTH;
					width <= 3'h1;
					cnt <= 6'h00;
					if (is_master && using_update) begin
						using_update <= 1'b0;
						events[`EV_FALLBACK] <= 1'b1;
						flash_addr <= golden_addr;
						cmd_sr <= {`CMD_READ_X1, golden_addr};
						flash_cs_b_o <= 1'b1;
						flash_sck_o <= 1'b0;
						lstate <= L_GAP;
					end else begin
						events[`EV_LOAD_ERR] <= 1'b1;
						lstate <= L_IDLE;
					end
				end else if (word_valid) begin
					case (pstate)
						P_WIDTH: begin
							pstate <= P_HDR;
							if (word_data != `SYNC_X1) begin
								width <= (word_data == `SYNC_X4) ? 3'h4 : 3'h2;
								cmd_sr <= {((word_data == `SYNC_X4) ? `CMD_READ_X4 : `CMD_READ_X2), flash_addr + 24'h00_0004};
								cnt <= 6'h00;
								flash_cs_b_o <= 1'b1;
								flash_sck_o <= 1'b0;
								lstate <= L_GAP;
							end
						end
						P_HDR: begin
							hdr_enc <= word_data[`HDR_ENC];
							hdr_auth <= word_data[`HDR_AUTH];
							base <= word_data[`HDR_BASE_LSB +: 6];
							count <= word_data[`HDR_COUNT_LSB +: 7];
							idx <= 7'h00;
							mac <= `MAC_INIT;
							if (!word_data[`HDR_PART]) begin
								cfg_valid <= 1'b0;
							end
							pstate <= P_BODY;
						end
						P_BODY: begin
							mac <= next_mac;
							idx <= idx + 7'h01;
							if (idx + 7'h01 == count) begin
								pstate <= P_TAG;
							end
						end
						default: begin
							cfg_valid <= 1'b1;
							events[`EV_DONE] <= 1'b1;
							pstate <= P_WIDTH;
							lstate <= L_IDLE;
						end
					endcase
				end
			end
		end
	end

	// Flash pins: command on line 0, write-protect and hold held high outside idle and slave states unless quad
	assign flash_dq_o = {2'h3, 1'b0, cmd_sr[31]};
	assign flash_dq_oe_o = {{2{(lstate != L_IDLE) && (lstate != L_SLAVE) && (width != 3'h4)}}, 1'b0, lstate == L_CMD};

	// Bus slave: writes take one edge, reads answer one edge later
	assign wr_slave = avs_write_i && (avs_address_i == `REG_SLAVE_DATA);
	assign avs_waitrequest_o = avs_read_i & ~rd_ack;
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			key_src <= 1'b0;
			ext_sel <= 1'b0;
			start_pulse <= 1'b0;
			status <= 4'h0;
			mask <= 4'h0;
			golden_addr <= 24'h00_0000;
			update_addr <= 24'h00_0000;
			rb_addr <= 6'h00;
			rd_ack <= 1'b0;
			avs_readdata_o <= 32'h0000_0000;
			for (j = 0; j < 8; j = j + 1) begin
				key_ram[j] <= 32'h0000_0000;
			end
		end else begin
			start_pulse <= avs_write_i && (avs_address_i == `REG_CTRL) && avs_writedata_i[`CTRL_START];
			// Sticky events: a set in the clearing cycle wins
			status <= (status & ~((avs_write_i && (avs_address_i == `REG_STATUS)) ? avs_writedata_i[3:0] : 4'h0))
				| events;
			if (avs_write_i) begin
				case (avs_address_i)
					`REG_CTRL: begin
						key_src <= avs_writedata_i[`CTRL_KEY_SRC];
						ext_sel <= avs_writedata_i[`CTRL_EXT_CLK];
					end
					`REG_MASK: mask <= avs_writedata_i[3:0];
					`REG_GOLDEN: golden_addr <= avs_writedata_i[23:0];
					`REG_UPDATE: update_addr <= avs_writedata_i[23:0];
					`REG_RB_ADDR: rb_addr <= avs_writedata_i[5:0];
					default: begin
						if (avs_address_i[5]) begin
							key_ram[avs_address_i[4:2]] <= avs_writedata_i;
						end
					end
				endcase
			end
			rd_ack <= avs_read_i & ~rd_ack;
			if (avs_read_i && !rd_ack) begin
				case (avs_address_i)
					`REG_CTRL: avs_readdata_o <= {29'h0, ext_sel, key_src, 1'b0};
					`REG_STATUS: avs_readdata_o <= {22'h0, using_update, cfg_valid, lstate != L_IDLE, width, status};
					`REG_MASK: avs_readdata_o <= {28'h0, mask};
					`REG_GOLDEN: avs_readdata_o <= {8'h00, golden_addr};
					`REG_UPDATE: avs_readdata_o <= {8'h00, update_addr};
					`REG_RB_ADDR: avs_readdata_o <= {26'h0, rb_addr};
					`REG_RB_DATA: avs_readdata_o <= cfg_mem[rb_addr];
					default: avs_readdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign irq_o = |(status & mask);
	assign done_o = cfg_valid;
endmodule

/* rtl/key_stream_cipher.v */
// Keyed word mixer: keystream word for decryption and running keyed digest for authentication.
// Assumes a 256-bit key held stable during a load; purely combinational.
`timescale 1ns/1ps
module key_stream_cipher (
	input wire [255:0] key_i,
	input wire [7:0] index_i,
	input wire [31:0] mac_i,
	input wire [31:0] word_i,
	output wire [31:0] stream_o,
	output wire [31:0] mac_o
);
	wire [2:0] sel0;
	wire [2:0] sel1;
	wire [31:0] k0;
	wire [31:0] k1;
	wire [31:0] r1;
	wire [31:0] r2;
	wire [31:0] m1;

	// Two rounds of key mixing per word index
	assign sel0 = index_i[2:0];
	assign sel1 = index_i[2:0] + 3'h3;
	assign k0 = key_i[{sel0, 5'h00} +: 32];
	assign k1 = key_i[{sel1, 5'h00} +: 32];
	assign r1 = k0 ^ {24'h00_0000, index_i};
	assign r2 = {r1[24:0], r1[31:25]} + k1;
	assign stream_o = r2 ^ {r2[18:0], r2[31:19]};

	// Digest step over the plain word, keyed by the same key word
	assign m1 = mac_i ^ word_i;
	assign mac_o = {m1[26:0], m1[31:27]} + k0;
endmodule

/* testbench/loader_checker.sv */
// Checker: bus handshake, flash pin framing and restart behaviour of the loader.
// Assumes it is bound to the loader top and sees only its ports.
`timescale 1ns/1ps
module loader_checker (
	input wire clock_i,
	input wire rst_b_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire avs_waitrequest_o,
	input wire program_b_i,
	input wire flash_cs_b_o,
	input wire flash_sck_o,
	input wire [3:0] flash_dq_o,
	input wire [3:0] flash_dq_oe_o,
	input wire done_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	// Read answers after exactly one wait state
	sequence s_one_wait;
		avs_waitrequest_o ##1 !avs_waitrequest_o;
	endsequence
	// Flash clock holds a whole tick after each change
	sequence s_tick_hold;
		$stable(flash_sck_o) [*3];
	endsequence
	a_read_one_wait: assert property ($rose(avs_read_i) |-> s_one_wait)
		else $error("read not answered after one wait");
	a_write_no_wait: assert property (avs_write_i |-> !avs_waitrequest_o)
		else $error("write stalled");
	a_idle_no_wait: assert property (!avs_read_i |-> !avs_waitrequest_o)
		else $error("stall without request");
	a_sck_tick_rate: assert property (!flash_cs_b_o && $changed(flash_sck_o) |=> s_tick_hold)
		else $error("flash clock tick too short");
	a_sck_idle_low: assert property (flash_cs_b_o && $past(flash_cs_b_o) |-> !flash_sck_o)
		else $error("flash clock not idle low");
	a_cmd_on_fall: assert property ($past(flash_dq_oe_o[0]) && flash_dq_oe_o[0] && $changed(flash_dq_o[0])
		|-> $fell(flash_sck_o)) else $error("command bit moved off a falling clock");
	a_cmd_oe_sel: assert property (flash_dq_oe_o[0] |-> !flash_cs_b_o && !flash_dq_oe_o[1])
		else $error("command line driven outside a session");
	a_restart_clears: assert property (!program_b_i [*5] |-> !done_o)
		else $error("configuration kept while restart held");
	a_done_deselect: assert property ($rose(done_o) |-> ##[0:8] flash_cs_b_o)
		else $error("flash still selected after done");
endmodule
bind config_bitstream_loader loader_checker chk_u (.clock_i, .rst_b_i, .avs_read_i, .avs_write_i,
	.avs_waitrequest_o, .program_b_i, .flash_cs_b_o, .flash_sck_o, .flash_dq_o, .flash_dq_oe_o, .done_o);

/* testbench/spi_flash_model.sv */
// SPI flash model: answers read commands 03, 3B and 6B from a word array.
// Assumes the loader shifts command bits on sck falls and samples data while sck is high.
`timescale 1ns/1ps
`include "cfg_loader_map.vh"
module spi_flash_model (
	input wire logic cs_b_i,
	input wire logic sck_i,
	input wire logic [3:0] dq_i,
	output logic [3:0] dq_o
);
	logic [31:0] mem [0:127];
	logic [31:0] cmd;
	int n = 0;
	int w = 1;
	int bp = 0;
	initial dq_o = 4'h5;
	// Command and address come in on dq0 at rising sck
	always @(posedge sck_i) if (!cs_b_i) begin
		if (n < 32) cmd = {cmd[30:0], dq_i[0]};
		n = n + 1;
		if (n == 32) begin
			w = cmd[31:24] == `CMD_READ_X4 ? 4 : cmd[31:24] == `CMD_READ_X2 ? 2 : 1;
			bp = cmd[23:0] * 8;
		end
	end
	// Data leaves on falling sck; idle lines toggle so no stale value looks valid
	always @(negedge sck_i or posedge cs_b_i) begin
		if (cs_b_i) begin
			n = 0;
			dq_o <= ~dq_o;
		end else if (n >= (w > 1 ? 40 : 32)) begin
			for (int i = 0; i < w; i++) begin
				dq_o[(w == 1) ? 1 : w - 1 - i] <= mem[(bp + i) / 32][31 - (bp + i) % 32];
			end
			bp = bp + w;
		end else begin
			dq_o <= ~dq_o;
		end
	end
endmodule

/* testbench/tb_top.sv */
// Testbench: boot from a model flash, update with fallback, slave partial load, readback, irq and restart.
// Assumes the loader register map header and the flash model in this folder.
`timescale 1ns/1ps
`include "cfg_loader_map.vh"
module tb_top;
	logic clock_i, rst_b_i, avs_read_i, avs_write_i, program_b_i, ext_cfg_clk_i;
	logic avs_waitrequest_o, flash_cs_b_o, flash_sck_o, done_o, irq_o;
	logic [5:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, d;
	logic [2:0] mode_i;
	logic [255:0] otp_key_fuses_i;
	logic [3:0] flash_dq_i, flash_dq_o, flash_dq_oe_o, mdl_dq;
	logic [31:0] slv [0:2] = '{32'h2004_0001, 32'h5A5A_0F0F, 32'h0000_0000};
	int num_errors = 0;
	int num_checks = 0;
	int k;
	config_bitstream_loader uut (.clock_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .program_b_i, .mode_i, .ext_cfg_clk_i,
		.otp_key_fuses_i, .flash_cs_b_o, .flash_sck_o, .flash_dq_i, .flash_dq_o, .flash_dq_oe_o, .done_o, .irq_o);
	spi_flash_model flash (.cs_b_i(flash_cs_b_o), .sck_i(flash_sck_o), .dq_i(flash_dq_o), .dq_o(mdl_dq));
	// Each data line carries whichever side enables it
	assign flash_dq_i = (flash_dq_oe_o & flash_dq_o) | (~flash_dq_oe_o & mdl_dq);
	// System clock and unrelated external configuration clock
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	initial begin
		ext_cfg_clk_i = 1'b0;
		#7;
		forever #200 ext_cfg_clk_i = ~ext_cfg_clk_i;
	end
	// Watchdog against a hung load
	initial begin
		#1_500_000;
		num_errors++;
		close_out();
	end
	task automatic close_out();
		if (num_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus transfer; holds the request until waitrequest is seen low
	task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] wd);
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= wd;
		avs_read_i <= rd;
		avs_write_i <= !rd;
		@(posedge clock_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
		d = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task automatic rchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b1, a, 32'h0000_0000);
		chk(d & m, e);
	endtask
	task automatic wait_done();
		k = 0;
		do begin
			xfer(1'b1, `REG_STATUS, 32'h0000_0000);
			k++;
		end while (d[`EV_DONE] !== 1'b1 && k < 3000);
		if (d[`EV_DONE] !== 1'b1) begin
			num_errors++;
			close_out();
		end
	endtask
	task automatic rb(input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, `REG_RB_ADDR, a);
		rchk(`REG_RB_DATA, 32'hFFFF_FFFF, e);
	endtask
	// Keystream and digest steps for a fuse key whose eight words are all 1357_9BDF
	function automatic logic [31:0] rotl(input logic [31:0] v, input int s);
		return (v << s) | (v >> (32 - s));
	endfunction
	function automatic logic [31:0] ks(input logic [7:0] ix);
		logic [31:0] r;
		r = rotl(32'h1357_9BDF ^ {24'h00_0000, ix}, 7) + 32'h1357_9BDF;
		return r ^ rotl(r, 13);
	endfunction
	function automatic logic [31:0] digest_step(input logic [31:0] m, input logic [31:0] w);
		return rotl(m ^ w, 5) + 32'h1357_9BDF;
	endfunction
	// Main sequence
	initial begin
		rst_b_i = 1'b0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 6'h00;
		avs_writedata_i = 32'h0000_0000;
		program_b_i = 1'b1;
		mode_i = `MODE_MASTER;
		otp_key_fuses_i = {8{32'h1357_9BDF}};
		flash.mem[0] = `SYNC_X4;
		flash.mem[1] = 32'h0000_0002;
		flash.mem[2] = 32'h1234_5678;
		flash.mem[3] = 32'hCAFE_0001;
		flash.mem[4] = 32'h0000_0000;
		flash.mem[64] = `SYNC_X2;
		flash.mem[65] = 32'h4000_0001;
		flash.mem[66] = 32'h0BAD_0BAD;
		flash.mem[67] = 32'h0000_0000;
		repeat (20) @(posedge clock_i);
		rst_b_i <= 1'b1;
		wait_done();
		chk(d & 32'h0000_03FF, 32'h0000_0141);
		rb(32'h0000_0000, 32'h1234_5678);
		rb(32'h0000_0001, 32'hCAFE_0001);
		chk(irq_o, 1'b0);
		xfer(1'b0, `REG_MASK, 32'h0000_0001);
		@(negedge clock_i);
		chk(irq_o, 1'b1);
		xfer(1'b0, `REG_STATUS, 32'h0000_000F);
		@(negedge clock_i);
		chk(irq_o, 1'b0);
		xfer(1'b0, `REG_UPDATE, 32'h0000_0100);
		xfer(1'b0, `REG_CTRL, 32'h0000_0005);
		wait_done();
		chk(d & 32'h0000_03FF, 32'h0000_014D);
		xfer(1'b0, `REG_STATUS, 32'h0000_000F);
		mode_i <= `MODE_SLAVE;
		repeat (4) @(posedge clock_i);
		xfer(1'b0, `REG_CTRL, 32'h0000_0001);
		for (int i = 0; i < 3; i++) xfer(1'b0, `REG_SLAVE_DATA, slv[i]);
		wait_done();
		chk(d & 32'h0000_0103, 32'h0000_0101);
		rb(32'h0000_0004, 32'h5A5A_0F0F);
		rb(32'h0000_0000, 32'h1234_5678);
		// Header with zero count is a load error in slave mode; config stays valid
		xfer(1'b0, `REG_STATUS, 32'h0000_000F);
		xfer(1'b0, `REG_CTRL, 32'h0000_0001);
		xfer(1'b0, `REG_SLAVE_DATA, 32'h0000_0000);
		repeat (2) @(posedge clock_i);
		rchk(`REG_STATUS, 32'h0000_0103, 32'h0000_0102);
		// Encrypted, authenticated partial load keyed from the fuses
		xfer(1'b0, `REG_STATUS, 32'h0000_000F);
		xfer(1'b0, `REG_CTRL, 32'h0000_0003);
		xfer(1'b0, `REG_SLAVE_DATA, 32'hE005_0001);
		xfer(1'b0, `REG_SLAVE_DATA, 32'h0123_4567 ^ ks(8'h00));
		xfer(1'b0, `REG_SLAVE_DATA, digest_step(`MAC_INIT, 32'h0123_4567));
		wait_done();
		chk(d & 32'h0000_010F, 32'h0000_0101);
		rb(32'h0000_0005, 32'h0123_4567);
		rb(32'h0000_0004, 32'h5A5A_0F0F);
		xfer(1'b0, `REG_KEY_BASE, 32'h0F0F_1234);
		rchk(`REG_KEY_BASE, 32'hFFFF_FFFF, 32'h0000_0000);
		mode_i <= `MODE_MASTER;
		program_b_i <= 1'b0;
		xfer(1'b0, `REG_STATUS, 32'h0000_000F);
		repeat (10) @(posedge clock_i);
		chk(done_o, 1'b0);
		program_b_i <= 1'b1;
		wait_done();
		chk(done_o, 1'b1);
		close_out();
	end
endmodule
